// ==== design/power_mode_pkg.sv ====
package power_mode_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [2:0]  CTL_OFFSET       = 3'h0;
    localparam logic [2:0]  CS_OFFSET        = 3'h4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] CTL_RESET        = 32'h0000_8000;
    localparam logic [31:0] CS_RESET         = 32'h0000_0000;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int          CTL_BANK2_OFF    = 21;
    localparam int          CTL_BANK1_OFF    = 20;
    localparam int          CTL_LOW_DRIVE    = 18;
    localparam int          CTL_OV_THRESH    = 15;
    localparam int          CTL_OV_ENABLE    = 14;
    localparam int          CTL_BKP_WEN      = 8;
    localparam int          CTL_UV_THR_LO    = 5;
    localparam int          CTL_UV_THR_HI    = 7;
    localparam int          CTL_UV_ENABLE    = 4;
    localparam int          CTL_STB_CLEAR    = 3;
    localparam int          CTL_WAKE_CLEAR   = 2;
    localparam int          CTL_STB_SELECT   = 1;
    localparam int          CTL_LOW_POWER    = 0;

    // ****************************************************************
    // Control and status register fields
    // ****************************************************************
    localparam int          CS_PIN1_EN       = 9;
    localparam int          CS_PIN0_EN       = 8;
    localparam int          CS_OV_FLAG       = 3;
    localparam int          CS_UV_FLAG       = 2;
    localparam int          CS_STB_FLAG      = 1;
    localparam int          CS_WAKE_FLAG     = 0;

    // ****************************************************************
    // Sleep outcome
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_DEEP_SLEEP,
        MODE_STANDBY
    } power_mode_t;

endpackage

// ==== design/power_mode_control_regs.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Bits 21/20 set: upper RAM bank powered off in deep-sleep; clear retains it.
// - Bit 18 set selects low-drive regulator during deep-sleep.
// - Bit 15 picks over-voltage threshold: 0 is 5V, 1 is 5.5V.
// - Bit 14 enables the over-voltage detector.
// - Backup-domain writes are blocked while bit 8 is 0, as after reset.
// - Bits 7:5 pick under-voltage threshold, ascending 2.9V to 4.6V.
// - Bit 4 enables the under-voltage detector.
// - Lock input makes under-voltage enable and threshold read-only.
// - Writing 1 to bit 3 clears standby flag; reads 0.
// - Writing 1 to bit 2 clears wake flag; reads 0.
// - Bit 1 picks deep-sleep (0) or standby (1) on a sleep request.
// - Bit 0 selects low-power regulator during deep-sleep.
// - Oscillator-fed peripheral in deep-sleep forces regulator back to normal power.
// - Control register resets to 0x00008000, also on standby exit.
// - Status register resets to zero and survives standby exit.
// - Status bits 8/9 enable wake pins; a rising edge wakes from standby.
// - Enabling a wake pin already high raises a wake event at once.
// - Wake pins active high, pull-down requested while enabled.
// - Status bit 3 shows supply at or above over-voltage level; off in standby.
// - Status bit 2 shows supply at or below under-voltage level; off in standby.
// - Status bit 1 set after standby; cleared only by power reset or clear bit.
// - Half-word and word accesses accepted; software uses only those sizes.
// - Status bit 0 set by wake pin or alarm; cleared by reset or clear bit.
module power_mode_control_regs
    import power_mode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_rst_i,
    input  wire logic        standby_exit_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [2:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sleep_deep_req_i,
    input  wire logic        periph_osc_active_i,
    input  wire logic        undervolt_config_lock_i,
    input  wire logic        overvolt_cmp_i,
    input  wire logic        undervolt_cmp_i,
    input  wire logic        standby_active_i,
    input  wire logic [1:0]  wake_pin_i,
    input  wire logic        alarm_wake_i,
    input  wire logic        backup_wr_req_i,
    output logic             backup_wr_allow_o,
    output logic             ram_bank2_power_off_o,
    output logic             ram_bank1_power_off_o,
    output logic             deep_sleep_low_drive_o,
    output logic             regulator_low_power_o,
    output logic             overvolt_detect_enable_o,
    output logic             overvolt_threshold_select_o,
    output logic             undervolt_detect_enable_o,
    output logic      [2:0]  undervolt_threshold_select_o,
    output logic      [1:0]  wake_pin_pulldown_o,
    output logic             standby_wake_o,
    output logic      [1:0]  power_mode_o
);

    // ****************************************************************
    // Stored fields
    // ****************************************************************
    logic        ram_bank2_power_off;
    logic        ram_bank1_power_off;
    logic        deep_sleep_low_drive;
    logic        overvolt_threshold_select;
    logic        overvolt_detect_enable;
    logic        backup_domain_write_enable;
    logic [2:0]  undervolt_threshold_select;
    logic        undervolt_detect_enable;
    logic        standby_select;
    logic        regulator_low_power;
    logic        wake_pin0_enable;
    logic        wake_pin1_enable;
    logic        overvolt_flag;
    logic        undervolt_flag;
    logic        standby_entered_flag;
    logic        wake_flag;
    logic [1:0]  wake_pin_prev;
    power_mode_t mode;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic        bus_req;
    logic        size_ok;
    logic        wr_ctl;
    logic        wr_cs;
    logic        lo_half;
    logic        hi_half;
    logic [1:0]  pin_enable;
    logic [1:0]  pin_enable_new;
    logic        wake_event;
    logic        in_deep_sleep;

    // New request only while no ack is out, so each access acks once
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Only half-word or word lane groups are taken; byte writes are dropped
    assign size_ok = (wb_sel_i == 4'hF) || (wb_sel_i == 4'h3) || (wb_sel_i == 4'hC);
    assign lo_half = wb_sel_i[0];
    assign hi_half = wb_sel_i[2];
    assign wr_ctl  = bus_req && wb_we_i && size_ok && (wb_adr_i == CTL_OFFSET);
    assign wr_cs   = bus_req && wb_we_i && size_ok && (wb_adr_i == CS_OFFSET);

    // Wishbone ack: one cycle after the strobe, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read mux; clear bits and reserved bits always read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == CTL_OFFSET) begin
                wb_dat_o[CTL_BANK2_OFF]                <= ram_bank2_power_off;
                wb_dat_o[CTL_BANK1_OFF]                <= ram_bank1_power_off;
                wb_dat_o[CTL_LOW_DRIVE]                <= deep_sleep_low_drive;
                wb_dat_o[CTL_OV_THRESH]                <= overvolt_threshold_select;
                wb_dat_o[CTL_OV_ENABLE]                <= overvolt_detect_enable;
                wb_dat_o[CTL_BKP_WEN]                  <= backup_domain_write_enable;
                wb_dat_o[CTL_UV_THR_HI:CTL_UV_THR_LO]  <= undervolt_threshold_select;
                wb_dat_o[CTL_UV_ENABLE]                <= undervolt_detect_enable;
                wb_dat_o[CTL_STB_SELECT]               <= standby_select;
                wb_dat_o[CTL_LOW_POWER]                <= regulator_low_power;
            end else if (wb_adr_i == CS_OFFSET) begin
                wb_dat_o[CS_PIN1_EN]   <= wake_pin1_enable;
                wb_dat_o[CS_PIN0_EN]   <= wake_pin0_enable;
                wb_dat_o[CS_OV_FLAG]   <= overvolt_flag;
                wb_dat_o[CS_UV_FLAG]   <= undervolt_flag;
                wb_dat_o[CS_STB_FLAG]  <= standby_entered_flag;
                wb_dat_o[CS_WAKE_FLAG] <= wake_flag;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************

    // Upper half: RAM bank switches and low-drive; standby exit reloads reset value
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_exit_rst_i) begin
            ram_bank2_power_off  <= CTL_RESET[CTL_BANK2_OFF];
            ram_bank1_power_off  <= CTL_RESET[CTL_BANK1_OFF];
            deep_sleep_low_drive <= CTL_RESET[CTL_LOW_DRIVE];
        end else if (wr_ctl && hi_half) begin
            ram_bank2_power_off  <= wb_dat_i[CTL_BANK2_OFF];
            ram_bank1_power_off  <= wb_dat_i[CTL_BANK1_OFF];
            deep_sleep_low_drive <= wb_dat_i[CTL_LOW_DRIVE];
        end
    end

    // Lower half: over-voltage detector, backup gate, mode select, low-power
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_exit_rst_i) begin
            overvolt_threshold_select  <= CTL_RESET[CTL_OV_THRESH];
            overvolt_detect_enable     <= CTL_RESET[CTL_OV_ENABLE];
            backup_domain_write_enable <= CTL_RESET[CTL_BKP_WEN];
            standby_select             <= CTL_RESET[CTL_STB_SELECT];
            regulator_low_power        <= CTL_RESET[CTL_LOW_POWER];
        end else if (wr_ctl && lo_half) begin
            overvolt_threshold_select  <= wb_dat_i[CTL_OV_THRESH];
            overvolt_detect_enable     <= wb_dat_i[CTL_OV_ENABLE];
            backup_domain_write_enable <= wb_dat_i[CTL_BKP_WEN];
            standby_select             <= wb_dat_i[CTL_STB_SELECT];
            regulator_low_power        <= wb_dat_i[CTL_LOW_POWER];
        end
    end

    // Under-voltage fields; the lock freezes them against software
    always_ff @(posedge clk_i) begin
        if (rst_i || standby_exit_rst_i) begin
            undervolt_threshold_select <= CTL_RESET[CTL_UV_THR_HI:CTL_UV_THR_LO];
            undervolt_detect_enable    <= CTL_RESET[CTL_UV_ENABLE];
        end else if (wr_ctl && lo_half && !undervolt_config_lock_i) begin
            undervolt_threshold_select <= wb_dat_i[CTL_UV_THR_HI:CTL_UV_THR_LO];
            undervolt_detect_enable    <= wb_dat_i[CTL_UV_ENABLE];
        end
    end

    // ****************************************************************
    // Control and status register
    // ****************************************************************

    assign pin_enable     = {wake_pin1_enable, wake_pin0_enable};
    assign pin_enable_new = {wb_dat_i[CS_PIN1_EN], wb_dat_i[CS_PIN0_EN]};

    // Wake pin enables; not touched by standby exit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_pin1_enable <= CS_RESET[CS_PIN1_EN];
            wake_pin0_enable <= CS_RESET[CS_PIN0_EN];
        end else if (wr_cs && lo_half) begin
            wake_pin1_enable <= wb_dat_i[CS_PIN1_EN];
            wake_pin0_enable <= wb_dat_i[CS_PIN0_EN];
        end
    end

    // Pin history; a pin enabled while high counts as an edge since history
    // is forced low while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_pin_prev <= 2'h0;
        end else begin
            wake_pin_prev <= wake_pin_i & pin_enable;
        end
    end

    // Event: rising edge on an enabled pin, incl. already high at enable, or alarm
    assign wake_event = (|(wake_pin_i & pin_enable & ~wake_pin_prev))
                        || alarm_wake_i;

    // Detector flags follow comparators only while enabled and awake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overvolt_flag  <= CS_RESET[CS_OV_FLAG];
            undervolt_flag <= CS_RESET[CS_UV_FLAG];
        end else begin
            overvolt_flag  <= overvolt_cmp_i && overvolt_detect_enable
                              && !standby_active_i;
            undervolt_flag <= undervolt_cmp_i && undervolt_detect_enable
                              && !standby_active_i;
        end
    end

    // Standby flag; cleared only by power reset or the clear bit, set beats clear
    always_ff @(posedge clk_i) begin
        if (por_rst_i) begin
            standby_entered_flag <= CS_RESET[CS_STB_FLAG];
        end else if (standby_active_i) begin
            standby_entered_flag <= 1'b1;
        end else if (wr_ctl && lo_half && wb_dat_i[CTL_STB_CLEAR]) begin
            standby_entered_flag <= 1'b0;
        end
    end

    // Wake flag; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_flag <= CS_RESET[CS_WAKE_FLAG];
        end else if (wake_event) begin
            wake_flag <= 1'b1;
        end else if (wr_ctl && lo_half && wb_dat_i[CTL_WAKE_CLEAR]) begin
            wake_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Sleep outcome and outputs
    // ****************************************************************

    // Mode chosen at each sleep request; leaving sleep returns to run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= MODE_RUN;
        end else begin
            case (mode)
                MODE_RUN: begin
                    if (sleep_deep_req_i) begin
                        mode <= standby_select ? MODE_STANDBY : MODE_DEEP_SLEEP;
                    end
                end
                MODE_DEEP_SLEEP: begin
                    if (!sleep_deep_req_i) begin
                        mode <= MODE_RUN;
                    end
                end
                MODE_STANDBY: begin
                    if (!sleep_deep_req_i) begin
                        mode <= MODE_RUN;
                    end
                end
                default: begin
                    mode <= MODE_RUN;
                end
            endcase
        end
    end

    assign in_deep_sleep = (mode == MODE_DEEP_SLEEP);

    // Registered outputs; deep-sleep options apply only in deep-sleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            backup_wr_allow_o            <= 1'b0;
            ram_bank2_power_off_o        <= 1'b0;
            ram_bank1_power_off_o        <= 1'b0;
            deep_sleep_low_drive_o       <= 1'b0;
            regulator_low_power_o        <= 1'b0;
            overvolt_detect_enable_o     <= 1'b0;
            overvolt_threshold_select_o  <= 1'b0;
            undervolt_detect_enable_o    <= 1'b0;
            undervolt_threshold_select_o <= 3'h0;
            wake_pin_pulldown_o          <= 2'h0;
            standby_wake_o               <= 1'b0;
            power_mode_o                 <= 2'h0;
        end else begin
            backup_wr_allow_o            <= backup_wr_req_i
                                            && backup_domain_write_enable;
            ram_bank2_power_off_o        <= in_deep_sleep && ram_bank2_power_off;
            ram_bank1_power_off_o        <= in_deep_sleep && ram_bank1_power_off;
            deep_sleep_low_drive_o       <= in_deep_sleep && deep_sleep_low_drive;
            // Oscillator-fed peripheral overrides low-power
            regulator_low_power_o        <= in_deep_sleep && regulator_low_power
                                            && !periph_osc_active_i;
            overvolt_detect_enable_o     <= overvolt_detect_enable && !standby_active_i;
            overvolt_threshold_select_o  <= overvolt_threshold_select;
            undervolt_detect_enable_o    <= undervolt_detect_enable && !standby_active_i;
            undervolt_threshold_select_o <= undervolt_threshold_select;
            wake_pin_pulldown_o          <= pin_enable;
            standby_wake_o               <= standby_active_i
                                            && (|(wake_pin_i & pin_enable & ~wake_pin_prev));
            power_mode_o                 <= mode;
        end
    end

endmodule

// ==== dv/power_mode_control_regs_monitor.sv ====
`timescale 1ns/1ps
module power_mode_control_regs_monitor
    import power_mode_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       por_rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       sleep_deep_req_i,
    input wire logic       periph_osc_active_i,
    input wire logic       standby_active_i,
    input wire logic       backup_wr_req_i,
    input wire logic       backup_wr_allow_o,
    input wire logic       ram_bank2_power_off_o,
    input wire logic       ram_bank1_power_off_o,
    input wire logic       deep_sleep_low_drive_o,
    input wire logic       regulator_low_power_o,
    input wire logic       overvolt_detect_enable_o,
    input wire logic       undervolt_detect_enable_o,
    input wire logic [1:0] wake_pin_pulldown_o,
    input wire logic       standby_wake_o,
    input wire logic [1:0] power_mode_o
);
    // ****************************************************
    // Checks
    // ****************************************************
    // Either reset silences every check
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    backup_gate_a: assert property (backup_wr_allow_o |-> $past(backup_wr_req_i))
        else $error("backup write allowed without request");
    ov_standby_a: assert property (overvolt_detect_enable_o |-> !$past(standby_active_i))
        else $error("overvoltage detector on in standby");
    uv_standby_a: assert property (undervolt_detect_enable_o |-> !$past(standby_active_i))
        else $error("undervoltage detector on in standby");
    osc_force_a: assert property (periph_osc_active_i && $past(periph_osc_active_i)
        |-> !regulator_low_power_o)
        else $error("low power kept while oscillator in use");
    // Deep-sleep options only act inside deep-sleep; allow one cycle of lag
    ram_mode_a: assert property (ram_bank2_power_off_o || ram_bank1_power_off_o ||
        deep_sleep_low_drive_o || regulator_low_power_o |-> power_mode_o == MODE_DEEP_SLEEP
        || $past(power_mode_o) == MODE_DEEP_SLEEP)
        else $error("deep-sleep option active outside deep-sleep");
    wake_standby_a: assert property (standby_wake_o |-> $past(standby_active_i))
        else $error("standby wake outside standby");
    pulldown_write_a: assert property ($changed(wake_pin_pulldown_o)
        |-> wb_ack_o || $past(wb_ack_o))
        else $error("pull-down changed without a write");
    mode_run_a: assert property (!$past(sleep_deep_req_i, 2) |-> power_mode_o == MODE_RUN)
        else $error("sleep mode without a request");
endmodule

bind power_mode_control_regs power_mode_control_regs_monitor mon (.clk_i, .rst_i,
    .por_rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_deep_req_i, .periph_osc_active_i,
    .standby_active_i, .backup_wr_req_i, .backup_wr_allow_o, .ram_bank2_power_off_o,
    .ram_bank1_power_off_o, .deep_sleep_low_drive_o, .regulator_low_power_o,
    .overvolt_detect_enable_o, .undervolt_detect_enable_o, .wake_pin_pulldown_o,
    .standby_wake_o, .power_mode_o);

// ==== dv/sleep_supply_model.sv ====
`timescale 1ns/1ps
// Processor sleep request, supply comparators, standby state and wake sources
module sleep_supply_model (
    input  wire logic       clk_i,
    output logic            sleep_req_o,
    output logic            ov_cmp_o,
    output logic            uv_cmp_o,
    output logic            standby_o,
    output logic [1:0]      pins_o,
    output logic            alarm_o
);
    // ****************************************************
    // Levels
    // ****************************************************
    // Pins rest low as the pull-down would hold them
    initial begin
        {sleep_req_o, ov_cmp_o, uv_cmp_o, standby_o, alarm_o} = 5'h00;
        pins_o = 2'h0;
    end

    // All changes land just after a rising edge
    task automatic set_levels(input logic r, ov, uv, sb, input logic [1:0] p, input logic a);
        @(posedge clk_i);
        sleep_req_o <= r;
        ov_cmp_o <= ov;
        uv_cmp_o <= uv;
        standby_o <= sb;
        pins_o <= p;
        alarm_o <= a;
    endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb
    import power_mode_pkg::*;
;
    logic clk_i, rst_i, por_i, sbx_i, cyc, stb, we, osc, lock, bkreq, wake_seen;
    logic [2:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    logic ack, allow, r2, r1, ld, lp, oven, ovthr, uven, swake, req, ov, uv, sb, alm;
    logic [2:0] uvthr;
    logic [1:0] pd, mode, pins;
    int num_errors = 0;
    int checks = 0;

    // ****************************************************
    // Clock, partner and design
    // ****************************************************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    sleep_supply_model far (.clk_i(clk_i), .sleep_req_o(req), .ov_cmp_o(ov), .uv_cmp_o(uv),
        .standby_o(sb), .pins_o(pins), .alarm_o(alm));
    power_mode_control_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .por_rst_i(por_i),
        .standby_exit_rst_i(sbx_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sleep_deep_req_i(req), .periph_osc_active_i(osc), .undervolt_config_lock_i(lock),
        .overvolt_cmp_i(ov), .undervolt_cmp_i(uv), .standby_active_i(sb),
        .wake_pin_i(pins), .alarm_wake_i(alm), .backup_wr_req_i(bkreq),
        .backup_wr_allow_o(allow), .ram_bank2_power_off_o(r2), .ram_bank1_power_off_o(r1),
        .deep_sleep_low_drive_o(ld), .regulator_low_power_o(lp),
        .overvolt_detect_enable_o(oven), .overvolt_threshold_select_o(ovthr),
        .undervolt_detect_enable_o(uven), .undervolt_threshold_select_o(uvthr),
        .wake_pin_pulldown_o(pd), .standby_wake_o(swake), .power_mode_o(mode));

    // Wake pulse lasts one cycle, so latch it for later checking
    always @(posedge clk_i) begin
        if (rst_i) wake_seen <= 1'b0;
        else if (swake === 1'b1) wake_seen <= 1'b1;
    end

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic wrap_up();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Classic cycle: hold request until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [2:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            wrap_up();
        end
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [3:0] s, input logic [31:0] d);
        bus(1'b1, a, s, d);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'hF, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic tick();
        repeat (3) @(posedge clk_i);
    endtask

    // ****************************************************
    // Sequence
    // ****************************************************
    initial begin
        {rst_i, por_i, sbx_i, cyc, stb, we, osc, lock, bkreq} = 9'h180;
        {adr, sel, dat} = '0;
        repeat (6) @(posedge clk_i);
        {rst_i, por_i} <= 2'b00;
        rd(CTL_OFFSET, CTL_RESET);
        rd(CS_OFFSET, CS_RESET);
        wr(CTL_OFFSET, 4'hF, 32'hFFFF_FFFF);
        rd(CTL_OFFSET, 32'h0034_C1F3);
        chk(32'({oven, ovthr, uven}), 32'h0000_0007);
        for (int k = 0; k < 8; k++) begin
            wr(CTL_OFFSET, 4'hF, 32'(k * 32 + 16));
            tick();
            chk(32'(uvthr), 32'(k));
        end
        lock <= 1'b1;
        wr(CTL_OFFSET, 4'hF, 32'h0000_0000);
        rd(CTL_OFFSET, 32'h0000_00F0);
        lock <= 1'b0;
        wr(CTL_OFFSET, 4'hF, 32'hFFFF_FFFF);
        wr(CTL_OFFSET, 4'h3, 32'h0000_0000);
        rd(CTL_OFFSET, 32'h0034_0000);
        wr(CTL_OFFSET, 4'hC, 32'h0000_0000);
        rd(CTL_OFFSET, 32'h0000_0000);
        wr(CTL_OFFSET, 4'h1, 32'hFFFF_FFFF);
        rd(CTL_OFFSET, 32'h0000_0000);
        rd(3'h2, 32'h0000_0000);
        bkreq <= 1'b1;
        tick();
        chk(32'(allow), 32'h0000_0000);
        wr(CTL_OFFSET, 4'hF, 32'h0000_0100);
        tick();
        chk(32'(allow), 32'h0000_0001);
        bkreq <= 1'b0;
        $display("registers done");
        wr(CTL_OFFSET, 4'hF, 32'h0000_4010);
        far.set_levels(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
        tick();
        rd(CS_OFFSET, 32'h0000_000C);
        far.set_levels(1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0);
        tick();
        rd(CS_OFFSET, 32'h0000_0002);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        @(posedge clk_i);
        sbx_i <= 1'b1;
        @(posedge clk_i);
        sbx_i <= 1'b0;
        rd(CTL_OFFSET, CTL_RESET);
        rd(CS_OFFSET, 32'h0000_0002);
        wr(CTL_OFFSET, 4'h3, 32'h0000_0008);
        rd(CS_OFFSET, 32'h0000_0000);
        rd(CTL_OFFSET, 32'h0000_0000);
        $display("flags done");
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0);
        wr(CS_OFFSET, 4'hF, 32'h0000_0100);
        tick();
        rd(CS_OFFSET, 32'h0000_0101);
        wr(CTL_OFFSET, 4'hF, 32'h0000_0004);
        rd(CS_OFFSET, 32'h0000_0100);
        wr(CS_OFFSET, 4'hF, 32'h0000_0300);
        tick();
        chk(32'(pd), 32'h0000_0003);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 1'b0);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0);
        tick();
        chk(32'(wake_seen), 32'h0000_0001);
        rd(CS_OFFSET, 32'h0000_0303);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        wr(CTL_OFFSET, 4'hF, 32'h0000_000C);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        tick();
        rd(CS_OFFSET, 32'h0000_0301);
        $display("wake done");
        wr(CTL_OFFSET, 4'hF, 32'h0034_0001);
        far.set_levels(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        tick();
        chk(32'(mode), 32'(MODE_DEEP_SLEEP));
        chk(32'({r2, r1, ld, lp}), 32'h0000_000F);
        osc <= 1'b1;
        tick();
        chk(32'(lp), 32'h0000_0000);
        osc <= 1'b0;
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        tick();
        chk(32'({mode, r2, r1, ld, lp}), 32'h0000_0000);
        wr(CTL_OFFSET, 4'hF, 32'h0034_0002);
        far.set_levels(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        tick();
        chk(32'({mode, r2, r1}), 32'(MODE_STANDBY) << 2);
        far.set_levels(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
        $display("sleep done");
        wrap_up();
    end
endmodule
